/* File: jtag_memory_read_and_release.v */
`timescale 1ns/1ns
`include "jtag_read_defines.vh"
module jtag_memory_read_and_release #(
  parameter ADDR_WIDTH = 20
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire tck_in,
  input wire tms_in,
  input wire tdi_in,
  output wire tdo_out,
  output wire tdo_oe_out,
  input wire debug_driven_cpu_clock_in,
  output wire [ADDR_WIDTH-1:0] internal_memory_address_bus_out,
  output wire mem_read_strobe_out,
  input wire [15:0] internal_memory_data_bus_in,
  input wire mem_read_valid_in,
  output wire read_select_out,
  output wire cpu_suspend_out,
  output wire debug_control_out,
  output wire power_on_reset_out,
  output wire brownout_reset_out,
  output wire boot_start_out
);
  localparam TLR = 4'h0;
  localparam RTI = 4'h1;
  localparam SEL_DR = 4'h2;
  localparam CAP_DR = 4'h3;
  localparam SH_DR = 4'h4;
  localparam EX1_DR = 4'h5;
  localparam PA_DR = 4'h6;
  localparam EX2_DR = 4'h7;
  localparam UP_DR = 4'h8;
  localparam SEL_IR = 4'h9;
  localparam CAP_IR = 4'hA;
  localparam SH_IR = 4'hB;
  localparam EX1_IR = 4'hC;
  localparam PA_IR = 4'hD;
  localparam EX2_IR = 4'hE;
  localparam UP_IR = 4'hF;

  localparam SEQ_IDLE = 2'h0;
  localparam SEQ_BOR = 2'h1;
  localparam SEQ_POR = 2'h2;

  // sequencer phase lengths in clk cycles, cut to the counter width
  localparam integer BOR_CYCLES_INT = `BOR_CYCLES;
  localparam integer POR_CYCLES_INT = `POR_CYCLES;
  localparam [15:0] BOR_COUNT = BOR_CYCLES_INT[15:0];
  localparam [15:0] POR_COUNT = POR_CYCLES_INT[15:0];
  localparam SW = `SHIFT_WIDTH;

  wire [3:0] pins_sync;
  reg [3:0] pins_prev_q;
  wire tck_s;
  wire tms_s;
  wire tdi_s;
  wire cpuclk_s;
  wire tck_rise;
  wire tck_fall;
  wire cpuclk_rise;

  reg [3:0] tap_q;
  reg [3:0] tap_d;
  reg [`IR_WIDTH-1:0] ir_q;
  reg [SW-1:0] sh_q;
  reg [SW-1:0] sh_d;
  reg [4:0] dr_len;
  reg tdo_q;
  reg [15:0] ctrl_q;
  reg [ADDR_WIDTH-1:0] addr_q;
  reg [15:0] data_q;
  reg strobe_q;
  reg [1:0] seq_q;
  reg [15:0] seq_cnt_q;
  reg boot_q;
  wire bor_request;
  // tdo enable, read tracking and sequencer decodes
  reg tdo_oe_q;
  reg read_pending_q;
  wire update_dr;
  wire bor_done;
  wire por_done;

  // pin synchroniser: tck, tms, tdi, cpu clock
  sync_2ff #(
    .WIDTH(4)
  ) pin_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .async_in({debug_driven_cpu_clock_in, tdi_in, tms_in, tck_in}),
    .sync_out(pins_sync)
  );

  assign tck_s = pins_sync[0];
  assign tms_s = pins_sync[1];
  assign tdi_s = pins_sync[2];
  assign cpuclk_s = pins_sync[3];

  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      pins_prev_q <= 4'h0;
    else
      pins_prev_q <= pins_sync;
  end

  assign tck_rise = tck_s & ~pins_prev_q[0];
  assign tck_fall = ~tck_s & pins_prev_q[0];
  assign cpuclk_rise = cpuclk_s & ~pins_prev_q[3];

  // tap state machine
  always @*
  begin
    case (tap_q)
      TLR: tap_d = tms_s ? TLR : RTI;
      RTI: tap_d = tms_s ? SEL_DR : RTI;
      SEL_DR: tap_d = tms_s ? SEL_IR : CAP_DR;
      CAP_DR: tap_d = tms_s ? EX1_DR : SH_DR;
      SH_DR: tap_d = tms_s ? EX1_DR : SH_DR;
      EX1_DR: tap_d = tms_s ? UP_DR : PA_DR;
      PA_DR: tap_d = tms_s ? EX2_DR : PA_DR;
      EX2_DR: tap_d = tms_s ? UP_DR : SH_DR;
      UP_DR: tap_d = tms_s ? SEL_DR : RTI;
      SEL_IR: tap_d = tms_s ? TLR : CAP_IR;
      CAP_IR: tap_d = tms_s ? EX1_IR : SH_IR;
      SH_IR: tap_d = tms_s ? EX1_IR : SH_IR;
      EX1_IR: tap_d = tms_s ? UP_IR : PA_IR;
      PA_IR: tap_d = tms_s ? EX2_IR : PA_IR;
      EX2_IR: tap_d = tms_s ? UP_IR : SH_IR;
      UP_IR: tap_d = tms_s ? SEL_DR : RTI;
      default: tap_d = TLR;
    endcase
  end

  // selected data register length
  always @*
  begin
    case (ir_q)
      `IR_ADDRESS_LOAD: dr_len = ADDR_WIDTH[4:0];
      `IR_DATA_TO_ADDRESS: dr_len = 5'd16;
      `IR_CONTROL_WORD_WRITE: dr_len = 5'd16;
      `IR_BROWNOUT_REGISTER: dr_len = 5'd16;
      default: dr_len = 5'd1;
    endcase
  end

  // shift register next value
  always @*
  begin
    sh_d = sh_q;
    case (tap_q)
      CAP_IR: sh_d = {{(SW-`IR_WIDTH){1'b0}}, `IR_CAPTURE_VALUE};
      SH_IR:
      begin
        sh_d = sh_q >> 1;
        sh_d[`IR_WIDTH-1] = tdi_s;
      end
      CAP_DR:
      begin
        case (ir_q)
          `IR_ADDRESS_LOAD: sh_d = {{(SW-ADDR_WIDTH){1'b0}}, addr_q};
          `IR_DATA_TO_ADDRESS: sh_d = {{(SW-16){1'b0}}, data_q};
          `IR_CONTROL_WORD_WRITE: sh_d = {{(SW-16){1'b0}}, ctrl_q};
          `IR_BROWNOUT_REGISTER: sh_d = {SW{1'b0}};
          default: sh_d = {SW{1'b0}};
        endcase
      end
      SH_DR:
      begin
        sh_d = sh_q >> 1;
        sh_d[dr_len-5'd1] = tdi_s;
      end
      default: sh_d = sh_q;
    endcase
  end

  // brownout request acts at the tck rise that leaves update-dr
  assign update_dr = tck_rise && (tap_q == UP_DR);
  assign bor_request = update_dr && (ir_q == `IR_BROWNOUT_REGISTER) && sh_q[`BROWNOUT_REQUEST_BIT];

  // tap, instruction and data registers
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      tap_q <= TLR;
      ir_q <= `IR_RESET_VALUE;
      sh_q <= {SW{1'b0}};
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
      ctrl_q <= `CTRL_RESET_VALUE;
      addr_q <= {ADDR_WIDTH{1'b0}};
    end
    else
    begin
      // tdo and its enable change on tck fall, so a driven tdo always holds a valid bit
      if (tck_fall)
      begin
        tdo_q <= sh_q[0];
        tdo_oe_q <= (tap_q == SH_DR) || (tap_q == SH_IR);
      end
      if (tck_rise)
      begin
        tap_q <= tap_d;
        sh_q <= sh_d;
        if (tap_q == TLR)
          ir_q <= `IR_RESET_VALUE;
        else if (tap_q == UP_IR)
          ir_q <= sh_q[`IR_WIDTH-1:0];
        if (tap_q == UP_DR && ir_q == `IR_CONTROL_WORD_WRITE)
          ctrl_q <= sh_q[15:0];
        // address only moves while the cpu clock is low
        if (tap_q == UP_DR && ir_q == `IR_ADDRESS_LOAD && !cpuclk_s)
          addr_q <= sh_q[ADDR_WIDTH-1:0];
      end
      if (seq_q != SEQ_IDLE || bor_request)
        ctrl_q <= `CTRL_RESET_VALUE;
    end
  end

  // memory read on cpu clock rise
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      strobe_q <= 1'b0;
      read_pending_q <= 1'b0;
      data_q <= 16'h0000;
    end
    else
    begin
      strobe_q <= cpuclk_rise && ctrl_q[`CTRL_READ_BIT] && ctrl_q[`CTRL_TAKE_CONTROL_BIT];
      // only the word answering our own strobe is kept; a new strobe wins over a late answer
      if (strobe_q)
        read_pending_q <= 1'b1;
      else if (mem_read_valid_in)
        read_pending_q <= 1'b0;
      if (mem_read_valid_in && read_pending_q)
        data_q <= internal_memory_data_bus_in;
    end
  end

  // last count of each sequencer phase
  assign bor_done = (seq_cnt_q == BOR_COUNT - 16'h0001);
  assign por_done = (seq_cnt_q == POR_COUNT - 16'h0001);

  // reset sequencer: brownout, then power-on, then boot start
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      seq_q <= SEQ_BOR;
      seq_cnt_q <= 16'h0000;
      boot_q <= 1'b0;
    end
    else
    begin
      boot_q <= 1'b0;
      case (seq_q)
        SEQ_IDLE:
        begin
          seq_cnt_q <= 16'h0000;
          if (bor_request)
            seq_q <= SEQ_BOR;
        end
        SEQ_BOR:
        begin
          if (bor_done)
          begin
            seq_cnt_q <= 16'h0000;
            seq_q <= SEQ_POR;
          end
          else
            seq_cnt_q <= seq_cnt_q + 16'h0001;
        end
        SEQ_POR:
        begin
          if (por_done)
          begin
            seq_cnt_q <= 16'h0000;
            seq_q <= SEQ_IDLE;
            boot_q <= 1'b1;
          end
          else
            seq_cnt_q <= seq_cnt_q + 16'h0001;
        end
        default: seq_q <= SEQ_IDLE;
      endcase
    end
  end

  assign tdo_out = tdo_q;
  assign tdo_oe_out = tdo_oe_q;
  assign internal_memory_address_bus_out = addr_q;
  assign mem_read_strobe_out = strobe_q;
  assign read_select_out = ctrl_q[`CTRL_READ_BIT];
  assign cpu_suspend_out = ctrl_q[`CTRL_SUSPEND_BIT];
  assign debug_control_out = ctrl_q[`CTRL_TAKE_CONTROL_BIT];
  assign power_on_reset_out = ctrl_q[`CTRL_POR_BIT] || (seq_q == SEQ_POR);
  assign brownout_reset_out = (seq_q == SEQ_BOR);
  assign boot_start_out = boot_q;
endmodule // jtag_memory_read_and_release

/* File: jtag_read_defines.vh */
// What this block does
// - a debug-requested power-on reset never brings a brownout reset with it
// - a real power-up runs brownout reset first, then power-on reset
// - boot code start is signalled only at the end of a brownout sequence
// - a dedicated scan register holds a brownout request bit
// - setting that bit drops debug control and runs the full brownout startup
// - read address loads onto the address bus only while the cpu clock is low
// - after the cpu clock rises the addressed word appears on the data bus
// - the captured data word is shifted out on tdo in a 16-bit scan
// - with the cpu clock low again the next read address is accepted
// - newest core: clock high, low, high after shift-out restores emulation state; this block keeps no emulation state to restore
`ifndef JTAG_READ_DEFINES_VH
`define JTAG_READ_DEFINES_VH

`define IR_WIDTH 8
`define IR_CAPTURE_VALUE 8'h01
`define IR_RESET_VALUE 8'hFF
`define IR_ADDRESS_LOAD 8'h83
`define IR_DATA_TO_ADDRESS 8'h85
`define IR_CONTROL_WORD_WRITE 8'h13
`define IR_BROWNOUT_REGISTER 8'h3A
`define IR_BYPASS 8'hFF

`define DATA_WIDTH 16
`define SHIFT_WIDTH 20
`define CTRL_RESET_VALUE 16'h0001
`define CTRL_READ_BIT 0
`define CTRL_SUSPEND_BIT 8
`define CTRL_TAKE_CONTROL_BIT 10
`define CTRL_POR_BIT 11
`define BROWNOUT_REQUEST_BIT 0

`define CLK_MHZ 100
`define BOR_TIME_NS 200
`define POR_TIME_NS 100
`define BOR_CYCLES ((`BOR_TIME_NS * `CLK_MHZ + 999) / 1000)
`define POR_CYCLES ((`POR_TIME_NS * `CLK_MHZ + 999) / 1000)

`endif

/* File: sync_2ff.v */
`timescale 1ns/1ns
module sync_2ff #(
  parameter WIDTH = 1
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // sync_2ff

/* File: jtag_read_asserts.sv */
`timescale 1ns/1ns
`include "jtag_read_defines.vh"
module jtag_read_asserts #(
  parameter ADDR_WIDTH = 20
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire debug_driven_cpu_clock_in,
  input wire [ADDR_WIDTH-1:0] internal_memory_address_bus_out,
  input wire mem_read_strobe_out,
  input wire read_select_out,
  input wire debug_control_out,
  input wire power_on_reset_out,
  input wire brownout_reset_out,
  input wire boot_start_out
);
  reg [7:0] bor_q;
  reg seen_q;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      bor_q <= 8'h00;
      seen_q <= 1'b0;
    end
    else
    begin
      bor_q <= brownout_reset_out ? bor_q + 8'h01 : 8'h00;
      if (brownout_reset_out)
        seen_q <= 1'b1;
      else if (boot_start_out)
        seen_q <= 1'b0;
    end
  end
  sequence s_bor_end;
    brownout_reset_out ##1 !brownout_reset_out;
  endsequence
  sequence s_por_hold;
    power_on_reset_out [*8];
  endsequence
  chk_bor_length: assert property ($fell(brownout_reset_out) |-> bor_q == `BOR_CYCLES)
    else $error("bor length");
  chk_bor_then_por: assert property (s_bor_end |-> s_por_hold)
    else $error("por after bor");
  chk_boot_after_bor: assert property (boot_start_out |-> seen_q)
    else $error("boot without bor");
  chk_por_no_bor: assert property ($rose(power_on_reset_out) && !$past(brownout_reset_out)
    |=> (!brownout_reset_out && !boot_start_out) [*8])
    else $error("debug por brought bor");
  chk_release_ctl: assert property ($rose(brownout_reset_out) |-> !debug_control_out && read_select_out)
    else $error("release kept control");
  chk_addr_clk_low: assert property ($changed(internal_memory_address_bus_out) |-> !debug_driven_cpu_clock_in)
    else $error("address moved with clock high");
  chk_read_strobe: assert property ($rose(debug_driven_cpu_clock_in) && read_select_out && debug_control_out
    |-> ##[1:6] mem_read_strobe_out)
    else $error("no read strobe");
  chk_strobe_pulse: assert property (mem_read_strobe_out |=> !mem_read_strobe_out)
    else $error("strobe too long");
endmodule // jtag_read_asserts
bind jtag_memory_read_and_release jtag_read_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) i_jtag_read_asserts (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .debug_driven_cpu_clock_in(debug_driven_cpu_clock_in),
  .internal_memory_address_bus_out(internal_memory_address_bus_out), .mem_read_strobe_out(mem_read_strobe_out),
  .read_select_out(read_select_out), .debug_control_out(debug_control_out),
  .power_on_reset_out(power_on_reset_out), .brownout_reset_out(brownout_reset_out),
  .boot_start_out(boot_start_out));

/* File: jtag_adapter_model.sv */
`timescale 1ns/1ns
module jtag_adapter_model (
  output reg tck_out,
  output reg tms_out,
  output reg tdi_out,
  output reg cpu_clk_out,
  input wire tdo_in
);
  initial
  begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
    cpu_clk_out = 1'b0;
  end
  task step(input reg m, input reg d, output reg o);
  begin
    tms_out = m;
    tdi_out = d;
    #62;
    o = tdo_in;
    tck_out = 1'b1;
    #63;
    tck_out = 1'b0;
  end
  endtask
  task tap_reset;
    reg o;
    integer i;
  begin
    for (i = 0; i < 6; i = i + 1)
      step(i < 5, 1'b0, o);
  end
  endtask
  task cpu(input reg v);
  begin
    cpu_clk_out = v;
    #100;
  end
  endtask
  task scan(input reg ir, input [19:0] v, input integer n, output reg [19:0] got);
    reg o;
    integer i;
  begin
    got = 20'h00000;
    step(1'b1, 1'b0, o);
    if (ir)
      step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (i = 0; i < n; i = i + 1)
    begin
      step(i == n - 1, v[i], o);
      got[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    tdi_out = ~tdi_out;
  end
  endtask
endmodule // jtag_adapter_model

/* File: jtag_memory_read_and_release_tb.sv */
`timescale 1ns/1ns
`include "jtag_read_defines.vh"
module jtag_memory_read_and_release_tb;
  reg clk_in = 1'b0;
  reg rst_b_in = 1'b0;
  reg mv = 1'b0;
  reg [15:0] md = 16'h0000;
  wire tck, tms, tdi, tdo, oe, susp, cpu, stb, rsel, dbg, por, bor, boot;
  wire [19:0] addr;
  reg [19:0] got;
  reg oe_seen = 1'b0;
  integer num_errors = 0;
  integer check_count = 0;
  jtag_adapter_model i_jtag_adapter_model (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .cpu_clk_out(cpu),
    .tdo_in(tdo));
  jtag_memory_read_and_release #(.ADDR_WIDTH(20)) i_jtag_memory_read_and_release (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(oe),
    .debug_driven_cpu_clock_in(cpu), .internal_memory_address_bus_out(addr), .mem_read_strobe_out(stb),
    .internal_memory_data_bus_in(md), .mem_read_valid_in(mv), .read_select_out(rsel), .cpu_suspend_out(susp),
    .debug_control_out(dbg), .power_on_reset_out(por), .brownout_reset_out(bor), .boot_start_out(boot));
  initial
    forever #5 clk_in = ~clk_in;
  function [15:0] word_at(input [19:0] a);
    word_at = a[15:0] ^ 16'h5A3C;
  endfunction
  always @(posedge clk_in)
  begin
    mv <= #1 stb;
    md <= #1 stb ? word_at(addr) : ~md;
    oe_seen <= oe_seen || oe;
  end
  task check(input [8*10:1] name, input [19:0] exp, input [19:0] seen);
  begin
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED %0s expected %h seen %h", name, exp, seen);
    end
  end
  endtask
  task sc(input reg ir, input [19:0] v, input integer n);
    i_jtag_adapter_model.scan(ir, v, n, got);
  endtask
  task hold(input reg w, input reg lvl, output integer n);
  begin
    n = 0;
    while (((w ? boot : bor) === lvl) && n < 99)
    begin
      @(posedge clk_in);
      #1 n = n + 1;
    end
  end
  endtask
  task boot_seq;
    integer n;
  begin
    hold(1'b0, 1'b0, n);
    hold(1'b0, 1'b1, n);
    check("bor time", 1'b1, n > `BOR_CYCLES - 5 && n <= `BOR_CYCLES + 1);
    check("por", 1'b1, por);
    hold(1'b1, 1'b0, n);
    check("boot", 1'b1, n > `POR_CYCLES - 2 && n <= `POR_CYCLES + 2);
  end
  endtask
  task test_debug_por;
  begin
    sc(1'b1, `IR_CONTROL_WORD_WRITE, 8);
    sc(1'b0, 20'h00C01, 16);
    check("por", 1'b1, por);
    check("bor", 1'b0, bor);
    sc(1'b0, 20'h00401, 16);
    check("por off", 1'b0, por);
    sc(1'b0, 20'h00501, 16);
    check("suspend", 1'b1, susp);
  end
  endtask
  task test_read;
    integer k;
    reg [19:0] a;
  begin
    i_jtag_adapter_model.cpu(1'b0);
    sc(1'b1, `IR_CONTROL_WORD_WRITE, 8);
    sc(1'b0, 20'h02409, 16);
    check("read sel", 1'b1, rsel);
    check("suspend", 1'b0, susp);
    for (k = 0; k < 2; k = k + 1)
    begin
      a = k ? 20'hA5C31 : 20'h0F0F0;
      sc(1'b1, `IR_ADDRESS_LOAD, 8);
      sc(1'b0, a, 20);
      check("address", a, addr);
      sc(1'b1, `IR_DATA_TO_ADDRESS, 8);
      i_jtag_adapter_model.cpu(1'b1);
      i_jtag_adapter_model.cpu(1'b0);
      sc(1'b0, 20'h00000, 16);
      check("data", word_at(a), got);
    end
    check("tdo oe", 1'b1, oe_seen);
    check("oe idle", 1'b0, oe);
    i_jtag_adapter_model.cpu(1'b1);
    sc(1'b1, `IR_ADDRESS_LOAD, 8);
    sc(1'b0, 20'h12345, 20);
    check("addr held", a, addr);
    i_jtag_adapter_model.cpu(1'b0);
    i_jtag_adapter_model.cpu(1'b1);
  end
  endtask
  task test_release;
  begin
    sc(1'b1, `IR_BROWNOUT_REGISTER, 8);
    sc(1'b0, 20'h00001, 16);
    check("debug ctl", 1'b0, dbg);
    boot_seq;
  end
  endtask
  task report_and_stop;
  begin
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  initial
  begin
    repeat (10) @(posedge clk_in);
    #1 rst_b_in = 1'b1;
    boot_seq;
    i_jtag_adapter_model.tap_reset;
    test_debug_por;
    test_read;
    test_release;
    report_and_stop;
  end
  initial
  begin
    #300000;
    num_errors = num_errors + 1;
    report_and_stop;
  end
endmodule // jtag_memory_read_and_release_tb
